// ### src/src_run_ctrl.sv
// run control of a motor starter: start/stop logic, reference scaling, wishbone registers
// Notes on behaviour
// - maintained mode: run while start input held, stop when released.
// - momentary mode: a start pulse latches run until stop input goes low.
// - momentary mode chosen if stop enabled and high at start rising edge.
// - start seal-in done internally; stop input low stops the motor in momentary mode only.
// - starter type setting selects phase control or current follower behaviour.
// - phase control: start command energizes every run-assigned relay.
// - phase control: firing level follows the scaled reference open-loop.
// - phase control: 0% gives no output, 100% gives full voltage.
// - current follower: firing regulated closed loop toward the current command.
// - current follower: 100% commands rated motor current, 0% none.
// - offset and span settings apply to the analog input before use.
// - ramp, kick and deceleration settings ignored in these two modes.
// - phase control keeps all listed protections active.
// - analog output option 10 shows firing level from 0 to 100%.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "src_consts.svh"
module src_run_ctrl
    import src_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // field inputs (asynchronous pins)
    input wire logic start_in_i,
    input wire logic stop_in_i,
    input wire logic [11:0] ain_i,
    input wire logic [15:0] current_i,
    input wire logic fault_i,
    // outputs
    output logic run_relay_o,
    output logic [15:0] firing_o,
    output logic [15:0] aout_o,
    output logic profile_en_o,
    output logic gates_en_o,
    output logic prot_en_o
);
    // registers
    logic [31:0] ctrl_q;
    logic [31:0] ain_cal_q;
    logic [15:0] rated_cur_q;
    logic sw_start_q;
    logic sw_stop_q;
    logic ack_q;
    src_type_t stype;
    logic [11:0] ain_off;
    logic [11:0] ain_span;
    logic [3:0] aout_sel;
    logic stop_en;
    assign stype = src_type_t'(ctrl_q[`SRC_CTRL_TYPE_LSB +: 2]);
    assign aout_sel = ctrl_q[`SRC_CTRL_AOUT_LSB +: 4];
    assign stop_en = ctrl_q[`SRC_CTRL_STOP_EN_BIT];
    assign ain_off = ain_cal_q[11:0];
    assign ain_span = ain_cal_q[27:16];

    // three-stage synchronisers; a change counts when stages two and three agree
    logic [2:0] start_s_q;
    logic [2:0] stop_s_q;
    logic start_f_q;
    logic stop_f_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_s_q <= 3'h0;
            stop_s_q <= 3'h0;
            start_f_q <= 1'b0;
            stop_f_q <= 1'b0;
        end else if (ce_i) begin
            start_s_q <= {start_s_q[1:0], start_in_i};
            stop_s_q <= {stop_s_q[1:0], stop_in_i};
            if (start_s_q[1] == start_s_q[2]) begin
                start_f_q <= start_s_q[2];
            end
            if (stop_s_q[1] == stop_s_q[2]) begin
                stop_f_q <= stop_s_q[2];
            end
        end
    end

    // multi-bit pins: three stages each, a word is taken only when stages two and three
    // agree, so a bus caught mid-change never reaches the scaling logic
    logic [11:0] ain_a_q;
    logic [11:0] ain_b_q;
    logic [11:0] ain_c_q;
    logic [11:0] ain_q;
    logic [15:0] cur_a_q;
    logic [15:0] cur_b_q;
    logic [15:0] cur_c_q;
    logic [15:0] cur_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ain_a_q <= 12'h000;
            ain_b_q <= 12'h000;
            ain_c_q <= 12'h000;
            ain_q <= 12'h000;
            cur_a_q <= 16'h0000;
            cur_b_q <= 16'h0000;
            cur_c_q <= 16'h0000;
            cur_q <= 16'h0000;
        end else if (ce_i) begin
            ain_a_q <= ain_i;
            ain_b_q <= ain_a_q;
            ain_c_q <= ain_b_q;
            if (ain_b_q == ain_c_q) begin
                ain_q <= ain_c_q;
            end
            cur_a_q <= current_i;
            cur_b_q <= cur_a_q;
            cur_c_q <= cur_b_q;
            if (cur_b_q == cur_c_q) begin
                cur_q <= cur_c_q;
            end
        end
    end

    // start edge and effective stop; stop input only counts when one is assigned
    logic start_lvl;
    logic start_prev_q;
    logic start_rise;
    logic stop_hi;
    assign start_lvl = start_f_q | sw_start_q;
    assign start_rise = start_lvl & ~start_prev_q;
    assign stop_hi = stop_en & stop_f_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_prev_q <= 1'b0;
        end else if (ce_i) begin
            start_prev_q <= start_lvl;
        end
    end

    // run state machine; a fault or software stop always wins
    src_state_t state_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= SRC_ST_IDLE;
        end else if (ce_i) begin
            case (state_q)
                SRC_ST_IDLE: begin
                    if (start_rise && !fault_i && !sw_stop_q) begin
                        if (stop_hi) begin
                            state_q <= SRC_ST_RUN3;
                        end else begin
                            state_q <= SRC_ST_RUN2;
                        end
                    end
                end
                SRC_ST_RUN2: begin
                    if (!start_lvl || fault_i || sw_stop_q) begin
                        state_q <= SRC_ST_IDLE;
                    end
                end
                SRC_ST_RUN3: begin
                    // sealed in: start release is ignored, stop low ends the run
                    if (!stop_hi || fault_i || sw_stop_q) begin
                        state_q <= SRC_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= SRC_ST_IDLE;
                end
            endcase
        end
    end
    logic running;
    assign running = (state_q == SRC_ST_RUN2) || (state_q == SRC_ST_RUN3);

    // offset and span, then clamp to 0..100.00 percent (units of 0.01%)
    logic [11:0] ain_rel;
    logic [25:0] pct_prod;
    logic [15:0] pct_raw;
    logic [15:0] ref_pct;
    always_comb begin
        ain_rel = (ain_q > ain_off) ? 12'(ain_q - ain_off) : 12'h000;
        pct_prod = 26'(ain_rel) * 26'(`SRC_PCT_FULL);
        if (ain_span == 12'h000) begin
            pct_raw = 16'h0000;
        end else begin
            pct_raw = (pct_prod / 26'(ain_span) > 26'(`SRC_PCT_FULL)) ?
                `SRC_PCT_FULL : 16'(pct_prod / 26'(ain_span));
        end
        ref_pct = (pct_raw > `SRC_PCT_FULL) ? `SRC_PCT_FULL : pct_raw;
    end

    // current command: reference scaled to rated motor current
    logic [31:0] cmd_prod;
    logic [15:0] cur_cmd;
    assign cmd_prod = 32'(ref_pct) * 32'(rated_cur_q);
    assign cur_cmd = 16'(cmd_prod / 32'(`SRC_PCT_FULL));

    // firing level in 0.01% units; closed loop steps one unit per cycle
    logic [15:0] firing_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            firing_q <= 16'h0000;
        end else if (ce_i) begin
            if (!running) begin
                firing_q <= 16'h0000;
            end else if (stype == SRC_TYPE_PHASE) begin
                firing_q <= ref_pct;
            end else if (stype == SRC_TYPE_CURR) begin
                // slow integrator: bounded slew keeps the loop stable on any load
                if (cur_cmd == 16'h0000) begin
                    firing_q <= 16'h0000;
                end else if (cur_q < cur_cmd && firing_q < `SRC_PCT_FULL) begin
                    firing_q <= firing_q + 16'h0001;
                end else if (cur_q > cur_cmd && firing_q != 16'h0000) begin
                    firing_q <= firing_q - 16'h0001;
                end
            end else begin
                firing_q <= 16'h0000; // other starter types drive no firing here
            end
        end
    end
    assign firing_o = firing_q;

    // mode-dependent outputs
    logic follow_mode;
    assign follow_mode = (stype == SRC_TYPE_PHASE) || (stype == SRC_TYPE_CURR);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_relay_o <= 1'b0;
            aout_o <= 16'h0000;
            profile_en_o <= 1'b0;
            gates_en_o <= 1'b0;
            prot_en_o <= 1'b0;
        end else if (ce_i) begin
            run_relay_o <= running;
            aout_o <= (aout_sel == `SRC_AOUT_FIRING) ? firing_q : 16'h0000;
            profile_en_o <= !follow_mode;
            gates_en_o <= running && follow_mode;
            prot_en_o <= 1'b1;
        end
    end

    // wishbone classic slave: ack one cycle after strobe, dropped the next cycle
    logic req;
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_q <= `SRC_CTRL_RESET;
            ain_cal_q <= `SRC_AIN_CAL_RESET;
            rated_cur_q <= `SRC_RATED_CUR_RESET;
            sw_start_q <= 1'b0;
            sw_stop_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= req;
            if (req && wb_we_i) begin
                case (wb_adr_i)
                    `SRC_ADR_CTRL: begin
                        for (int i = 0; i < 4; i++) begin
                            if (wb_sel_i[i]) begin
                                ctrl_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                            end
                        end
                    end
                    `SRC_ADR_AIN_CAL: begin
                        for (int i = 0; i < 4; i++) begin
                            if (wb_sel_i[i]) begin
                                ain_cal_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                            end
                        end
                    end
                    `SRC_ADR_RATED_CUR: begin
                        for (int i = 0; i < 2; i++) begin
                            if (wb_sel_i[i]) begin
                                rated_cur_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                            end
                        end
                    end
                    `SRC_ADR_CMD: begin
                        if (wb_sel_i[0]) begin
                            sw_start_q <= wb_dat_i[0];
                            sw_stop_q <= wb_dat_i[1];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    // reserved control bits read as zero whatever was written there
                    `SRC_ADR_CTRL: wb_dat_o <= {19'h0, ctrl_q[12], 4'h0, ctrl_q[7:4], 2'h0,
                        ctrl_q[1:0]};
                    `SRC_ADR_AIN_CAL: wb_dat_o <= {4'h0, ain_cal_q[27:16], 4'h0, ain_cal_q[11:0]};
                    `SRC_ADR_RATED_CUR: wb_dat_o <= {16'h0, rated_cur_q};
                    `SRC_ADR_STATUS: wb_dat_o <= {firing_q, 8'h0, 2'h0, stop_hi,
                        start_f_q, run_relay_o, state_q, running};
                    `SRC_ADR_CMD: wb_dat_o <= {30'h0, sw_stop_q, sw_start_q};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign wb_ack_o = ack_q;
endmodule : src_run_ctrl

// ### src/src_consts.svh
// register offsets, field positions, reset values and scaling constants of the run control block
`ifndef SRC_CONSTS_SVH
`define SRC_CONSTS_SVH
`define SRC_ADR_CTRL 8'h00
`define SRC_ADR_AIN_CAL 8'h04
`define SRC_ADR_RATED_CUR 8'h08
`define SRC_ADR_STATUS 8'h0c
`define SRC_ADR_CMD 8'h10
`define SRC_CTRL_TYPE_LSB 0
`define SRC_CTRL_AOUT_LSB 4
`define SRC_CTRL_STOP_EN_BIT 12
`define SRC_CTRL_RESET 32'h0000_0000
`define SRC_AIN_CAL_RESET 32'h0fff_0000
`define SRC_RATED_CUR_RESET 16'h0064
`define SRC_AOUT_FIRING 4'ha
`define SRC_PCT_FULL 16'h2710
`define SRC_AIN_W 12
`endif

// ### src/src_pkg.sv
// types of the run control block
package src_pkg;
    typedef enum logic [1:0] {
        SRC_TYPE_SOFT = 2'b00,
        SRC_TYPE_PHASE = 2'b01,
        SRC_TYPE_CURR = 2'b10,
        SRC_TYPE_OTHER = 2'b11
    } src_type_t;
    typedef enum logic [1:0] {
        SRC_ST_IDLE = 2'b00,
        SRC_ST_RUN2 = 2'b01,
        SRC_ST_RUN3 = 2'b10
    } src_state_t;
endpackage : src_pkg

// ### verif/src_field_model.sv
// operator side model: hand/off/auto selector, pushbuttons, plc run contact
`timescale 1ns/1ps
module src_field_model (
    // operator and plc controls
    input wire logic hand_i,
    input wire logic start_pb_i,
    input wire logic stop_pb_i,
    input wire logic plc_run_i,
    // master unit: run relay and 0..100.00% analog output, plus the bench's own reference
    input wire logic master_i,
    input wire logic mst_run_i,
    input wire logic [15:0] mst_level_i,
    input wire logic [11:0] man_ain_i,
    // wiring toward the starter
    output logic start_o,
    output logic stop_o,
    output logic [11:0] ain_o
);
    logic [31:0] mst_code;
    logic local_start;
    // stop is wired ahead of start, so a pressed stop also blocks start
    assign stop_o = hand_i & ~stop_pb_i;
    assign local_start = hand_i ? (stop_o & start_pb_i) : plc_run_i;
    // a master's run relay replaces the local contacts and its output spans the full code
    assign start_o = master_i ? mst_run_i : local_start;
    assign mst_code = (32'(mst_level_i) * 32'h0000_0fff) / 32'h0000_2710;
    assign ain_o = master_i ? mst_code[11:0] : man_ain_i;
endmodule : src_field_model

// ### verif/src_run_ctrl_monitor.sv
// port checker of the run control block
`timescale 1ns/1ps
`include "src_consts.svh"
module src_run_ctrl_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // field side
    input wire logic fault_i,
    input wire logic run_relay_o,
    input wire logic [15:0] firing_o,
    input wire logic [15:0] aout_o,
    input wire logic profile_en_o,
    input wire logic gates_en_o,
    input wire logic prot_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request not yet answered, and a held trip
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_trip;
        fault_i [*4];
    endsequence
    // bus answer: one cycle late, one cycle long, never unasked
    a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // protections stay on from the second edge after reset
    a_prot_on: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> prot_en_o)
        else $error("protection off");
    a_mode_excl: assert property (!(profile_en_o && gates_en_o))
        else $error("profile active in gated mode");
    a_fire_clamp: assert property (firing_o <= `SRC_PCT_FULL)
        else $error("firing above full");
    // aout may lag firing by one register stage
    a_aout_src: assert property (aout_o == 16'h0 || aout_o == firing_o ||
        aout_o == $past(firing_o)) else $error("aout not from firing");
    a_trip_stop: assert property (s_trip |-> !run_relay_o)
        else $error("relay held through a trip");
endmodule : src_run_ctrl_monitor

bind src_run_ctrl src_run_ctrl_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .fault_i, .run_relay_o, .firing_o, .aout_o, .profile_en_o, .gates_en_o, .prot_en_o);

// ### verif/tb.sv
// self-checking bench of the run control block
`timescale 1ns/1ps
`include "src_consts.svh"
module tb;
    // clock, reset and bus
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic req = 1'h0;
    logic wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] rd;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    // field side
    logic hand = 1'h0, spb = 1'h0, tpb = 1'h0, plc = 1'h0, fault_i = 1'h0;
    logic [11:0] ain_i = 12'h000;
    logic [15:0] current_i = 16'h0000;
    logic [15:0] f;
    logic mst = 1'h0;
    logic mst_run = 1'h0;
    logic [15:0] mst_lvl = 16'h0000;
    wire [11:0] ain_w;
    wire start_in_i, stop_in_i, run_relay_o, profile_en_o, gates_en_o, prot_en_o;
    wire [15:0] firing_o, aout_o;
    int num_errors = 0;
    int n_checks = 0;
    int cyc_n = 0;
    // reference sweep: last three entries use offset 0x100, span 0x400
    logic [11:0] t_ain [6] = '{12'hfff, 12'h800, 12'h000, 12'h300, 12'h600, 12'h050};
    logic [15:0] t_exp [6] = '{16'h2710, 16'h1389, 16'h0, 16'h1388, 16'h2710, 16'h0};

    src_field_model u_fld (.hand_i(hand), .start_pb_i(spb), .stop_pb_i(tpb),
        .plc_run_i(plc), .master_i(mst), .mst_run_i(mst_run), .mst_level_i(mst_lvl),
        .man_ain_i(ain_i), .start_o(start_in_i), .stop_o(stop_in_i), .ain_o(ain_w));
    src_run_ctrl u_dut (.clk_i, .rst_i, .ce_i(1'h1), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .start_in_i, .stop_in_i, .ain_i(ain_w), .current_i, .fault_i, .run_relay_o,
        .firing_o, .aout_o, .profile_en_o, .gates_en_o, .prot_en_o);

    always #2.5 clk_i = ~clk_i;

    task test_done();
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            num_errors = num_errors + 1;
            test_done();
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one classic cycle, held until the edge that samples ack
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'h1);
        rd = wb_dat_o;
        req <= 1'h0;
    endtask : wb

    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'h1, a, d);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        chk("rdata", e, rd);
    endtask : rdc

    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // pins pass a filter, so the relay is given a bounded time
    task wait_rel(input logic v);
        for (int i = 0; i < 40 && run_relay_o !== v; i++) @(posedge clk_i);
        chk("relay", v, run_relay_o);
    endtask : wait_rel

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        rdc(`SRC_ADR_CTRL, `SRC_CTRL_RESET);
        rdc(`SRC_ADR_AIN_CAL, `SRC_AIN_CAL_RESET);
        rdc(`SRC_ADR_RATED_CUR, {16'h0, `SRC_RATED_CUR_RESET});
        wr(8'h14, 32'hffff_ffff);
        rdc(8'h14, 32'h0);
        chk("prot", 1'h1, prot_en_o);
        // phase control, aout on firing, stop assigned, reserved bits set
        wr(`SRC_ADR_CTRL, 32'hffff_ffad);
        rdc(`SRC_ADR_CTRL, 32'h0000_10a1);
        ain_i <= 12'hfff;
        plc <= 1'h1;
        wait_rel(1'h1);
        chk("gates", 1'h1, gates_en_o);
        chk("profile", 1'h0, profile_en_o);
        for (int i = 0; i < 6; i++) begin
            if (i == 3) wr(`SRC_ADR_AIN_CAL, 32'h0400_0100);
            ain_i <= t_ain[i];
            tick(16);
            chk("firing", t_exp[i], firing_o);
            chk("aout", t_exp[i], aout_o);
        end
        fault_i <= 1'h1;
        tick(6);
        chk("trip", 1'h0, run_relay_o);
        fault_i <= 1'h0;
        plc <= 1'h0;
        wait_rel(1'h0);
        // hand position: momentary start, latched until stop
        hand <= 1'h1;
        tick(8);
        spb <= 1'h1;
        tick(8);
        spb <= 1'h0;
        wait_rel(1'h1);
        tick(30);
        chk("sealed", 1'h1, run_relay_o);
        tpb <= 1'h1;
        wait_rel(1'h0);
        tpb <= 1'h0;
        tick(30);
        chk("stays off", 1'h0, run_relay_o);
        // stop not assigned: the same pulse is only maintained
        wr(`SRC_ADR_CTRL, 32'h0000_00a1);
        spb <= 1'h1;
        wait_rel(1'h1);
        spb <= 1'h0;
        wait_rel(1'h0);
        // a master unit gives start through its run relay and reference through its output
        wr(`SRC_ADR_AIN_CAL, `SRC_AIN_CAL_RESET);
        mst <= 1'h1;
        mst_lvl <= `SRC_PCT_FULL;
        mst_run <= 1'h1;
        wait_rel(1'h1);
        tick(16);
        chk("slave firing", `SRC_PCT_FULL, firing_o);
        mst_run <= 1'h0;
        wait_rel(1'h0);
        mst <= 1'h0;
        // current follower with rated current 0x32
        hand <= 1'h0;
        wr(`SRC_ADR_CTRL, 32'h0000_00a2);
        wr(`SRC_ADR_RATED_CUR, 32'h0000_0032);
        wr(`SRC_ADR_AIN_CAL, 32'h0fff_0000);
        ain_i <= 12'hfff;
        plc <= 1'h1;
        wait_rel(1'h1);
        tick(40);
        f = firing_o;
        tick(20);
        chk("rising", 1'h1, firing_o > f);
        current_i <= 16'h0032;
        tick(6);
        f = firing_o;
        tick(10);
        chk("holding", 1'h1, firing_o == f);
        current_i <= 16'h0033;
        tick(10);
        chk("falling", 1'h1, firing_o < f);
        ain_i <= 12'h000;
        tick(16);
        chk("zero cmd", 16'h0, firing_o);
        plc <= 1'h0;
        wait_rel(1'h0);
        wr(`SRC_ADR_CTRL, 32'h0);
        tick(4);
        chk("profile", 1'h1, profile_en_o);
        // software start and stop through the command register; status shows the run
        wr(`SRC_ADR_CMD, 32'h0000_0001);
        wait_rel(1'h1);
        rdc(`SRC_ADR_STATUS, 32'h0000_000b);
        wr(`SRC_ADR_CMD, 32'h0000_0002);
        wait_rel(1'h0);
        wr(`SRC_ADR_CMD, 32'h0000_0003);
        tick(8);
        chk("stop wins", 1'h0, run_relay_o);
        rdc(`SRC_ADR_CMD, 32'h0000_0003);
        test_done();
    end
endmodule : tb
